/* File: ees_pkg.sv */
/*
  Shared constants and types of the two-wire serial memory slave.
  Assumes a 200 MHz system clock sampling the bus pins.
*/
package ees_pkg;

  localparam int unsigned CLK_PERIOD_NS       = 5;
  localparam int unsigned WRITE_CYCLE_TIME_MS = 10;
  // Longest time: integer division rounds down
  localparam int unsigned WRITE_CYCLE_CLKS    =
    (WRITE_CYCLE_TIME_MS * 1000000) / CLK_PERIOD_NS;

  localparam int unsigned TIMER_W  = 22;
  localparam int unsigned ADDR_W   = 9;
  localparam int unsigned MEM_SIZE = 512;

  localparam logic [3:0] LAST_BIT  = 4'h7;
  localparam logic [3:0] ACK_SLOT  = 4'h8;
  localparam logic [3:0] CNT_RST   = 4'h0;
  // Loaded at start: the start's own clock fall wraps it to zero
  localparam logic [3:0] CNT_START = 4'hf;
  localparam logic [7:0] BYTE_RST  = 8'h00;
  localparam logic [8:0] PTR_RST   = 9'h000;
  localparam logic [8:0] SMALL_MSK = 9'h0ff;
  localparam logic [8:0] LARGE_MSK = 9'h1ff;
  localparam logic [2:0] SYNC_RST  = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_BADR,
    ST_DATA,
    ST_RD,
    ST_HOLD,
    ST_PROG
  } ees_state_t;

endpackage : ees_pkg

/* File: ees_slave.sv */
/*
  Two-wire serial memory slave: start/stop detection, address match,
  byte write with timed programming, sequential read, upper-half protect.
  Assumes the bus pins are asynchronous and oversampled by mclk_i, and
  that the open-drain wire is resolved outside from sda_o/sda_oe_n_o.
*/
// Behaviour
// - Programming ends within ten milliseconds
// - Bus ignored, line released while programming
// - Device is slave, master clocks
// - Data line only pulled low or released
// - Unconnected select pins compare as zero; here they must be held low outside
// - Small variant compares all three selects
// - Large variant: select bit zero is address
// - Protect pin makes upper half read-only
// - Protect low allows full array access
// - Falling data, clock high, is start
// - Rising data, clock high, is stop
// - Upper nibble must match device type
// - Address bit zero selects read/write
// - Matching address is acknowledged
// - Receiver pulls low in ninth clock
// - Every unprotected written byte acknowledged
// - Read: release, sample ack, continue
// - Read without ack: stop, await stop
// - Byte write loads address pointer first
// - Stop after data starts programming
// - Protected data byte refused, not programmed
`timescale 1ns/1ps

module ees_slave #(
  parameter bit          LARGE_VARIANT = 1'b1,
  parameter logic [3:0]  DEV_TYPE      = 4'h6, // Arbitrary value
  parameter int unsigned WRITE_CYCLES  = ees_pkg::WRITE_CYCLE_CLKS
) (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic clk_en_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output wire logic sda_o,
  output wire logic sda_oe_n_o,
  input  wire logic chip_select_bit_zero_i,
  input  wire logic chip_select_bit_one_i,
  input  wire logic chip_select_bit_two_i,
  input  wire logic write_protect_i,
  output wire logic busy_o
);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers and filters

  logic [2:0]          scl_sync_ff;
  logic [2:0]          sda_sync_ff;
  logic                scl_f_ff;
  logic                sda_f_ff;
  logic                scl_d_ff;
  logic                sda_d_ff;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      scl_sync_ff <= ees_pkg::SYNC_RST;
      sda_sync_ff <= ees_pkg::SYNC_RST;
    end else if (clk_en_i) begin
      scl_sync_ff <= {scl_sync_ff[1:0], scl_i};
      sda_sync_ff <= {sda_sync_ff[1:0], sda_i};
    end
  end

  // A level counts only once stages two and three agree
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      scl_f_ff <= 1'b1;
      sda_f_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else if (clk_en_i) begin
      if (scl_sync_ff[1] == scl_sync_ff[2]) begin
        scl_f_ff <= scl_sync_ff[2];
      end
      if (sda_sync_ff[1] == sda_sync_ff[2]) begin
        sda_f_ff <= sda_sync_ff[2];
      end
      scl_d_ff <= scl_f_ff;
      sda_d_ff <= sda_f_ff;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise  = scl_f_ff & ~scl_d_ff;
  assign scl_fall  = ~scl_f_ff & scl_d_ff;
  assign start_det = scl_f_ff & scl_d_ff & sda_d_ff & ~sda_f_ff;
  assign stop_det  = scl_f_ff & scl_d_ff & ~sda_d_ff & sda_f_ff;

  ////////////////////////////////////////////////////////////////////
  // Address decode helpers

  logic [8:0] ptr_msk;
  logic       sel_match;
  logic       dev_match;
  logic       protect_hit;

  logic [ees_pkg::ADDR_W-1:0] ptr_ff;
  logic [7:0]                 rx_ff;

  assign ptr_msk = LARGE_VARIANT ? ees_pkg::LARGE_MSK : ees_pkg::SMALL_MSK;

  // Select pins must be strapped; a floating pin is held low outside
  always_comb begin
    if (LARGE_VARIANT) begin
      sel_match = (rx_ff[3:2] == {chip_select_bit_two_i,
                                  chip_select_bit_one_i});
    end else begin
      sel_match = (rx_ff[3:1] == {chip_select_bit_two_i,
                                  chip_select_bit_one_i,
                                  chip_select_bit_zero_i});
    end
  end

  assign dev_match = (rx_ff[7:4] == DEV_TYPE) && sel_match;

  // Upper half read-only under protect; else full access
  assign protect_hit = write_protect_i &&
    (LARGE_VARIANT ? ptr_ff[8] : ptr_ff[7]);

  ////////////////////////////////////////////////////////////////////
  // Bus engine

  ees_pkg::ees_state_t state_ff;
  logic [3:0]          cnt_ff;
  logic [7:0]          tx_ff;
  logic                pull_ff;
  logic                mack_ff;
  logic                pend_ff;
  logic [7:0]          pend_data_ff;
  logic [8:0]          pend_addr_ff;
  logic                busy_ff;
  logic [ees_pkg::TIMER_W-1:0] timer_ff;
  logic [7:0]          mem [ees_pkg::MEM_SIZE];
  logic                prog_done;

  assign prog_done = (timer_ff == '0);

  // Received bits and master acknowledge sampled on rising clock
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rx_ff   <= ees_pkg::BYTE_RST;
      mack_ff <= 1'b0;
    end else if (clk_en_i && scl_rise) begin
      if (cnt_ff == ees_pkg::ACK_SLOT) begin
        mack_ff <= ~sda_f_ff;
      end else begin
        rx_ff <= {rx_ff[6:0], sda_f_ff};
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_ff     <= ees_pkg::ST_IDLE;
      cnt_ff       <= ees_pkg::CNT_RST;
      tx_ff        <= ees_pkg::BYTE_RST;
      pull_ff      <= 1'b0;
      pend_ff      <= 1'b0;
      pend_data_ff <= ees_pkg::BYTE_RST;
      pend_addr_ff <= ees_pkg::PTR_RST;
      ptr_ff       <= ees_pkg::PTR_RST;
    end else if (clk_en_i) begin
      if (state_ff == ees_pkg::ST_PROG) begin
        // Bus interface disabled while programming
        pull_ff <= 1'b0;
        if (prog_done) begin
          state_ff <= ees_pkg::ST_IDLE;
        end
      end else if (start_det) begin
        state_ff <= ees_pkg::ST_DEV;
        cnt_ff   <= ees_pkg::CNT_START;
        pull_ff  <= 1'b0;
        pend_ff  <= 1'b0;
      end else if (stop_det) begin
        cnt_ff  <= ees_pkg::CNT_RST;
        pull_ff <= 1'b0;
        if (pend_ff) begin
          state_ff <= ees_pkg::ST_PROG;
          pend_ff  <= 1'b0;
        end else begin
          state_ff <= ees_pkg::ST_IDLE;
        end
      end else if (scl_fall && state_ff != ees_pkg::ST_IDLE
                   && state_ff != ees_pkg::ST_HOLD) begin
        case (cnt_ff)
          ees_pkg::LAST_BIT: begin
            cnt_ff  <= ees_pkg::ACK_SLOT;
            pull_ff <= 1'b0;
            case (state_ff)
              ees_pkg::ST_DEV: begin
                if (dev_match) begin
                  pull_ff <= 1'b1;
                  if (LARGE_VARIANT) begin
                    ptr_ff[8] <= rx_ff[1];
                  end
                end else begin
                  state_ff <= ees_pkg::ST_HOLD;
                end
              end
              ees_pkg::ST_BADR: begin
                pull_ff     <= 1'b1;
                ptr_ff[7:0] <= rx_ff;
              end
              ees_pkg::ST_DATA: begin
                if (protect_hit) begin
                  state_ff <= ees_pkg::ST_HOLD;
                  pend_ff  <= 1'b0;
                end else begin
                  pull_ff      <= 1'b1;
                  pend_ff      <= 1'b1;
                  pend_data_ff <= rx_ff;
                  pend_addr_ff <= ptr_ff & ptr_msk;
                  ptr_ff       <= (ptr_ff + 9'h001) & ptr_msk;
                end
              end
              default: begin
                // Read: release for the master's acknowledge
                pull_ff <= 1'b0;
              end
            endcase
          end
          ees_pkg::ACK_SLOT: begin
            cnt_ff  <= ees_pkg::CNT_RST;
            pull_ff <= 1'b0;
            case (state_ff)
              ees_pkg::ST_DEV: begin
                if (rx_ff[0]) begin
                  state_ff <= ees_pkg::ST_RD;
                  tx_ff    <= mem[ptr_ff & ptr_msk];
                  pull_ff  <= ~mem[ptr_ff & ptr_msk][7];
                  ptr_ff   <= (ptr_ff + 9'h001) & ptr_msk;
                end else begin
                  state_ff <= ees_pkg::ST_BADR;
                end
              end
              ees_pkg::ST_BADR: begin
                state_ff <= ees_pkg::ST_DATA;
              end
              ees_pkg::ST_RD: begin
                if (mack_ff) begin
                  tx_ff   <= mem[ptr_ff & ptr_msk];
                  pull_ff <= ~mem[ptr_ff & ptr_msk][7];
                  ptr_ff  <= (ptr_ff + 9'h001) & ptr_msk;
                end else begin
                  state_ff <= ees_pkg::ST_HOLD;
                end
              end
              default: begin
                state_ff <= state_ff;
              end
            endcase
          end
          default: begin
            cnt_ff <= cnt_ff + 4'h1;
            if (state_ff == ees_pkg::ST_RD) begin
              tx_ff   <= {tx_ff[6:0], 1'b0};
              pull_ff <= ~tx_ff[6];
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Self-timed programming

  // Array written at the stop; the timer only models the busy window
  always_ff @(posedge mclk_i) begin
    if (clk_en_i && rst_n_i && stop_det && pend_ff
        && state_ff != ees_pkg::ST_PROG) begin
      mem[pend_addr_ff] <= pend_data_ff;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      timer_ff <= '0;
      busy_ff  <= 1'b0;
    end else if (clk_en_i) begin
      if (state_ff != ees_pkg::ST_PROG && stop_det && pend_ff
          && !start_det) begin
        timer_ff <= ees_pkg::TIMER_W'(WRITE_CYCLES - 1);
        busy_ff  <= 1'b1;
      end else if (state_ff == ees_pkg::ST_PROG) begin
        if (prog_done) begin
          busy_ff <= 1'b0;
        end else begin
          timer_ff <= timer_ff - 1'b1;
        end
      end
    end
  end

  // Open drain: drive only low, enable active low
  assign sda_o      = 1'b0;
  assign sda_oe_n_o = ~pull_ff;
  assign busy_o     = busy_ff;

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_prog_release: assert property (busy_ff |-> !pull_ff)
    else $error("line pulled while programming");
  a_prog_starts: assert property (
    clk_en_i && stop_det && pend_ff && !start_det
    && state_ff != ees_pkg::ST_PROG |=> busy_ff)
    else $error("programming not started at stop");
  a_prog_bound: assert property (
    busy_ff |-> timer_ff < ees_pkg::TIMER_W'(WRITE_CYCLES))
    else $error("programming timer exceeds limit");
  a_prog_end: assert property (
    busy_ff && prog_done && clk_en_i |=> !busy_ff)
    else $error("programming did not end");
  a_addr_ack: assert property (
    clk_en_i && scl_fall && !start_det && !stop_det
    && state_ff == ees_pkg::ST_DEV && cnt_ff == ees_pkg::LAST_BIT
    && dev_match |=> pull_ff && cnt_ff == ees_pkg::ACK_SLOT)
    else $error("matching address not acknowledged");
  a_addr_nack: assert property (
    clk_en_i && scl_fall && !start_det && !stop_det
    && state_ff == ees_pkg::ST_DEV && cnt_ff == ees_pkg::LAST_BIT
    && !dev_match |=> !pull_ff ##1 !pull_ff)
    else $error("mismatched address acknowledged");
  a_wp_refuse: assert property (
    clk_en_i && scl_fall && !start_det && !stop_det
    && state_ff == ees_pkg::ST_DATA && cnt_ff == ees_pkg::LAST_BIT
    && protect_hit |=> !pull_ff && !pend_ff)
    else $error("protected byte accepted");
  a_idle_quiet: assert property (
    state_ff == ees_pkg::ST_IDLE |-> !pull_ff)
    else $error("line pulled before start");
  a_rd_release: assert property (
    state_ff == ees_pkg::ST_RD && cnt_ff == ees_pkg::ACK_SLOT
    |-> !pull_ff)
    else $error("read ack slot not released");
  a_rd_nack_hold: assert property (
    clk_en_i && scl_fall && !start_det && !stop_det
    && state_ff == ees_pkg::ST_RD && cnt_ff == ees_pkg::ACK_SLOT
    && !mack_ff |=> state_ff == ees_pkg::ST_HOLD && !pull_ff)
    else $error("read continued without ack");
  a_rx_released: assert property (
    state_ff != ees_pkg::ST_RD && cnt_ff != ees_pkg::ACK_SLOT
    |-> !pull_ff)
    else $error("line pulled outside ack slot");

  c_byte_write: cover property (
    state_ff == ees_pkg::ST_DATA && stop_det && pend_ff);
  c_seq_read: cover property (
    state_ff == ees_pkg::ST_RD && cnt_ff == ees_pkg::ACK_SLOT
    && scl_fall && mack_ff);
  c_addr_miss: cover property (
    state_ff == ees_pkg::ST_DEV && cnt_ff == ees_pkg::LAST_BIT
    && scl_fall && !dev_match);
  c_wp_refuse: cover property (
    state_ff == ees_pkg::ST_DATA && cnt_ff == ees_pkg::LAST_BIT
    && scl_fall && protect_hit);

endmodule : ees_slave

/* File: ees_master.sv */
/*
  Behavioural two-wire bus master that drives the memory slave.
  Assumes the bench resolves the open-drain data wire with a pull-up.
*/
`timescale 1ns/1ps

module ees_master (
  input  wire logic mclk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // Idle bus: clock high, data released
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  // Quarter of a 160 ns bus clock period
  task automatic q();
    repeat (8) @(posedge mclk_i);
  endtask : q

  // Data falls while clock high
  task automatic start_c();
    sda_low_o <= 1'b0;
    q();
    scl_o <= 1'b1;
    q();
    sda_low_o <= 1'b1;
    q();
    scl_o <= 1'b0;
    q();
  endtask : start_c

  // Data rises while clock high
  task automatic stop_c();
    sda_low_o <= 1'b1;
    q();
    scl_o <= 1'b1;
    q();
    sda_low_o <= 1'b0;
    q();
  endtask : stop_c

  // Clock low with data released: no start, no stop
  task automatic idle_low();
    scl_o <= 1'b0;
    q();
  endtask : idle_low

  // Data only changes with clock low
  task automatic xfer_bit(input logic b, output logic r);
    sda_low_o <= ~b;
    q();
    scl_o <= 1'b1;
    q();
    r = sda_i;
    q();
    scl_o <= 1'b0;
    q();
  endtask : xfer_bit

  // MSB first, ninth clock left released for the receiver
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
    xfer_bit(1'b1, r);
    ack = ~r;
  endtask : tx

  // Master pulls low on the ninth clock to ask for more
  task automatic rx(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, r);
      d[i] = r;
    end
    xfer_bit(~ack, r);
  endtask : rx
endmodule : ees_master

/* File: ees_slave_tb.sv */
/*
  Self-checking bench of the memory slave, large variant plus a small one.
  Assumes ees_master as bus partner and a pulled-up data wire.
*/
`timescale 1ns/1ps

module ees_slave_tb;
  localparam int unsigned WCYC = 2000;
  localparam logic [3:0]  TYPE = 4'h6; // Arbitrary type nibble

  logic       mclk    = 1'b0;
  logic       rst_n   = 1'b0;
  logic       wp      = 1'b0;
  logic       scl;
  logic       mst_low;
  logic       sda_o;
  logic       sda_oe_n;
  logic       busy;
  logic       sda_oe_n_s;
  logic       sda;
  logic       ack;
  logic [7:0] d;
  int         bad_count = 0;
  int         n_checks  = 0;

  always #2.5 mclk = ~mclk;

  assign sda = (mst_low || (!sda_oe_n && !sda_o) || !sda_oe_n_s) ? 1'b0 : 1'b1;

  // Select bit zero tied high: ignored on the large variant
  ees_slave #(.LARGE_VARIANT(1'b1), .DEV_TYPE(TYPE), .WRITE_CYCLES(WCYC)) u_dut (
    .mclk_i                 (mclk),
    .rst_n_i                (rst_n),
    .clk_en_i               (1'b1),
    .scl_i                  (scl),
    .sda_i                  (sda),
    .sda_o                  (sda_o),
    .sda_oe_n_o             (sda_oe_n),
    .chip_select_bit_zero_i (1'b1),
    .chip_select_bit_one_i  (1'b1),
    .chip_select_bit_two_i  (1'b0),
    .write_protect_i        (wp),
    .busy_o                 (busy)
  );

  // Small variant on the same wire, strapped to select 111
  ees_slave #(.LARGE_VARIANT(1'b0), .DEV_TYPE(TYPE), .WRITE_CYCLES(WCYC)) u_dut_small (
    .mclk_i                 (mclk),
    .rst_n_i                (rst_n),
    .clk_en_i               (1'b1),
    .scl_i                  (scl),
    .sda_i                  (sda),
    .sda_o                  (),
    .sda_oe_n_o             (sda_oe_n_s),
    .chip_select_bit_zero_i (1'b1),
    .chip_select_bit_one_i  (1'b1),
    .chip_select_bit_two_i  (1'b1),
    .write_protect_i        (wp),
    .busy_o                 ()
  );

  ees_master u_mst (
    .mclk_i    (mclk),
    .sda_i     (sda),
    .scl_o     (scl),
    .sda_low_o (mst_low)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  function automatic logic [7:0] dev(input logic a8, input logic rw);
    return {TYPE, 1'b0, 1'b1, a8, rw};
  endfunction : dev

  // Byte write; optional acknowledge poll while programming
  task automatic wr(input logic [8:0] a, input logic [7:0] v, input logic e, input logic poll);
    int n;
    u_mst.start_c();
    u_mst.tx(dev(a[8], 1'b0), ack);
    check("wr_dev_ack", ack, 1'b1);
    u_mst.tx(a[7:0], ack);
    check("wr_badr_ack", ack, 1'b1);
    u_mst.tx(v, ack);
    check("wr_data_ack", ack, e);
    u_mst.stop_c();
    check("busy_start", busy, e);
    if (poll) begin
      u_mst.start_c();
      u_mst.tx(dev(a[8], 1'b0), ack);
      check("poll_nack", ack, 1'b0);
      check("poll_release", sda_oe_n, 1'b1);
      u_mst.stop_c();
    end
    n = 0;
    while (busy !== 1'b0 && n < 3 * WCYC) begin
      @(posedge mclk);
      n++;
    end
    check("busy_len", (n <= WCYC && (!e || poll || n + 64 >= WCYC)), 1'b1);
  endtask : wr

  // Selective read of two bytes: first acked, second not
  task automatic rd2(input logic [8:0] a, input logic [7:0] e0, input logic [7:0] e1);
    u_mst.start_c();
    u_mst.tx(dev(a[8], 1'b0), ack);
    u_mst.tx(a[7:0], ack);
    u_mst.start_c();
    u_mst.tx(dev(a[8], 1'b1), ack);
    check("rd_dev_ack", ack, 1'b1);
    u_mst.rx(1'b1, d);
    check("rd_byte0", d, e0);
    u_mst.rx(1'b0, d);
    check("rd_byte1", d, e1);
    u_mst.q();
    check("rd_nack_release", sda_oe_n, 1'b1);
    u_mst.stop_c();
  endtask : rd2

  //////////////////////////////////////////////////////////////////////////////
  // Pointer crosses from 0x0ff into the upper half
  task automatic t_write_read();
    wr(9'h0ff, 8'h3c, 1'b1, 1'b0);
    wr(9'h100, 8'hc3, 1'b1, 1'b1);
    rd2(9'h0ff, 8'h3c, 8'hc3);
    check("open_drain_value", sda_o, 1'b0);
  endtask : t_write_read

  task automatic t_protect();
    wp <= 1'b1;
    wr(9'h100, 8'h55, 1'b0, 1'b0);
    wr(9'h0fe, 8'h77, 1'b1, 1'b0);
    rd2(9'h0fe, 8'h77, 8'h3c);
    rd2(9'h0ff, 8'h3c, 8'hc3);
    wp <= 1'b0;
  endtask : t_protect

  task automatic t_refuse();
    u_mst.idle_low();
    u_mst.tx(dev(1'b0, 1'b0), ack);
    check("no_start_nack", ack, 1'b0);
    u_mst.stop_c();
    u_mst.start_c();
    u_mst.tx({TYPE ^ 4'h3, 4'h6}, ack);
    check("type_nack", ack, 1'b0);
    u_mst.tx(8'h00, ack);
    check("mismatch_quiet", ack, 1'b0);
    u_mst.stop_c();
    u_mst.start_c();
    u_mst.tx({TYPE, 4'hc}, ack);
    check("select_nack", ack, 1'b0);
    u_mst.stop_c();
    u_mst.start_c();
    u_mst.tx({TYPE, 4'he}, ack);
    check("small_select_ack", ack, 1'b1);
    u_mst.stop_c();
  endtask : t_refuse

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #250000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    // Settling time stands in for the power-up wait
    repeat (8) @(posedge mclk);
    t_write_read();
    t_protect();
    t_refuse();
    tally_and_finish();
  end
endmodule : ees_slave_tb
